/* hdl/acp_pkg.sv */
// ======================================================================
package acp_pkg;
    // ==================================================================
    // register map
    localparam logic [5:0] REG_THR_ACT    = 6'h24;
    localparam logic [5:0] REG_THR_INACT  = 6'h25;
    localparam logic [5:0] REG_TIME_INACT = 6'h26;
    localparam logic [5:0] REG_RATE       = 6'h2c;
    localparam logic [5:0] REG_SLEEP_LINK = 6'h2d;
    localparam logic [5:0] REG_INT_EN     = 6'h2e;
    localparam logic [5:0] REG_INT_CAUSE  = 6'h30;
    localparam logic [5:0] REG_FORMAT     = 6'h31;
    localparam logic [5:0] REG_AXIS_LOW_BYTE    = 6'h32;
    localparam logic [5:0] REG_AXIS_HIGH_BYTE    = 6'h33;
    localparam logic [5:0] REG_DATA_Y0    = 6'h34;
    localparam logic [5:0] REG_DATA_Y1    = 6'h35;
    localparam logic [5:0] REG_DATA_Z0    = 6'h36;
    localparam logic [5:0] REG_DATA_Z1    = 6'h37;
    localparam logic [5:0] REG_INT_CLR    = 6'h3a;
    // ==================================================================
    // field positions
    localparam int FMT_SELFTEST_BIT = 7;
    localparam int FMT_FIXSENS_BIT  = 3;
    localparam int FMT_JUSTIFY_BIT  = 2;
    localparam int RATE_LOWPWR_BIT  = 4;
    localparam int SL_LINK_BIT      = 5;
    localparam int SL_AUTOSLEEP_BIT = 4;
    localparam int SL_SLEEP_BIT     = 2;
    localparam int INT_DRDY_BIT     = 7;
    localparam int INT_ACT_BIT      = 4;
    localparam int INT_INACT_BIT    = 3;
    // ==================================================================
    // reset values and codes
    localparam logic [7:0] RATE_RST      = 8'h0a;
    localparam logic [7:0] FMT_RST       = 8'h00;
    localparam logic [7:0] SL_RST        = 8'h00;
    localparam logic [7:0] INT_EN_RST    = 8'h00;
    localparam logic [7:0] THR_RST       = 8'h00;
    localparam logic [3:0] RATE_3200     = 4'hf;
    localparam logic [3:0] RATE_1600     = 4'he;
    localparam logic [3:0] SLEEP_RATE    = 4'h4;
    localparam logic [1:0] RANGE_HALF_G  = 2'h0;
    localparam int         THR_SHIFT     = 4;
    localparam int         BASE_BITS     = 10;
    localparam int         WORD_W        = 16;
    localparam int         RAW_W         = 13;
    // ==================================================================
    // carriers
    typedef struct packed {
        logic       selftest;
        logic       fixsens;
        logic       justify;
        logic [1:0] range;
    } acp_fmt_t;
    typedef struct packed {
        logic sleep;
        logic autosleep;
        logic link;
    } acp_mode_t;
    typedef struct packed {
        logic signed [RAW_W-1:0] x;
        logic signed [RAW_W-1:0] y;
        logic signed [RAW_W-1:0] z;
    } acp_axes_t;
    typedef struct packed {
        logic act;
        logic inact;
    } acp_evt_t;
endpackage

/* hdl/acp_format.sv */
`timescale 1ns/100ps
module acp_format
#(
    parameter int RAW_W = acp_pkg::RAW_W
)
(
    input  wire logic signed [RAW_W-1:0] raw_i,
    input  wire acp_pkg::acp_fmt_t       fmt_i,
    input  wire logic                    high_rate_i,
    output logic [15:0]                  word_o
);
    logic        [4:0]  nbits;
    logic        [1:0]  shr;
    logic signed [15:0] ext;
    logic signed [15:0] val;
    logic signed [15:0] hi;
    logic signed [15:0] lo;

    always_comb
    begin
        nbits = fmt_i.fixsens ? 5'(acp_pkg::BASE_BITS) + {3'h0, fmt_i.range}
                              : 5'(acp_pkg::BASE_BITS);
        shr   = fmt_i.fixsens ? 2'h0 : fmt_i.range;
        ext   = {{(16-RAW_W){raw_i[RAW_W-1]}}, raw_i};
        val   = ext >>> shr;
        hi    = 16'sh7fff >>> (5'd16 - nbits);
        lo    = ~hi;
        // saturate rather than wrap when the input exceeds the range
        if (val > hi)
            val = hi;
        else if (val < lo)
            val = lo;
        if (high_rate_i && (fmt_i.fixsens || fmt_i.range == acp_pkg::RANGE_HALF_G))
            val[0] = 1'b0;
        word_o = fmt_i.justify ? 16'(val << (5'd16 - nbits)) : val;
    end
endmodule

/* hdl/acp_sleep_ctl.sv */
`timescale 1ns/100ps
module acp_sleep_ctl
(
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              ce_i,
    input  wire acp_pkg::acp_mode_t mode_i,
    input  wire logic              act_hit_i,
    input  wire logic              inact_hit_i,
    input  wire logic              act_pending_i,
    output logic                   asleep_o,
    output logic                   act_en_o,
    output logic                   inact_en_o,
    output acp_pkg::acp_evt_t      evt_o
);
    typedef enum logic [1:0] {ACP_AWAKE, ACP_LINK_WAIT, ACP_ASLEEP} acp_sleep_t;
    acp_sleep_t state;
    acp_sleep_t next_state;
    logic       auto_on;

    always_comb
    begin
        auto_on      = mode_i.link && mode_i.autosleep;
        next_state   = state;
        evt_o.act    = 1'b0;
        evt_o.inact  = 1'b0;
        act_en_o     = 1'b1;
        inact_en_o   = 1'b1;
        asleep_o     = mode_i.sleep;
        unique case (state)
            ACP_AWAKE:
            begin
                act_en_o    = !mode_i.link;
                evt_o.act   = act_hit_i && !mode_i.link;
                evt_o.inact = inact_hit_i;
                if (inact_hit_i && mode_i.link)
                    next_state = (auto_on && !act_pending_i) ? ACP_ASLEEP : ACP_LINK_WAIT;
            end
            ACP_LINK_WAIT:
            begin
                inact_en_o = 1'b0;
                evt_o.act  = act_hit_i;
                if (act_hit_i || !mode_i.link)
                    next_state = ACP_AWAKE;
            end
            ACP_ASLEEP:
            begin
                inact_en_o = 1'b0;
                asleep_o   = 1'b1;
                evt_o.act  = act_hit_i;
                if (act_hit_i || !auto_on)
                    next_state = ACP_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state <= ACP_AWAKE;
        else if (ce_i)
            state <= next_state;
    end
endmodule

/* hdl/acp_top.sv */
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module acp_top
#(
    parameter int RAW_W = acp_pkg::RAW_W
)
(
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              ce_i,
    input  wire logic [5:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [7:0]             rdata_o,
    input  wire logic              sample_valid_i,
    input  wire acp_pkg::acp_axes_t sample_i,
    output logic                   irq_o,
    output logic                   selftest_o,
    output logic                   low_power_o,
    output logic                   asleep_o
);
    // ==================================================================
    // declarations
    logic [7:0]  rate_power_reg;
    logic [7:0]  sleep_link_reg;
    logic [7:0]  format_reg;
    logic [7:0]  int_en;
    logic [7:0]  thr_act;
    logic [7:0]  thr_inact;
    logic [7:0]  time_inact;
    logic [7:0]  next_rate_power_reg;
    logic [7:0]  next_sleep_link_reg;
    logic [7:0]  next_format_reg;
    logic [7:0]  next_int_en;
    logic [7:0]  next_thr_act;
    logic [7:0]  next_thr_inact;
    logic [7:0]  next_time_inact;
    logic [7:0]  status;
    logic [7:0]  next_status;
    logic        next_irq;
    logic [7:0]  next_rdata;
    logic        next_selftest;
    logic        next_low_power;
    logic        next_asleep;
    logic [15:0] dec_cnt;
    logic [15:0] next_dec_cnt;
    logic [7:0]  idle_cnt;
    logic [7:0]  next_idle_cnt;
    logic [15:0] axis_x;
    logic [15:0] axis_y;
    logic [15:0] axis_z;
    logic [15:0] next_axis_x;
    logic [15:0] next_axis_y;
    logic [15:0] next_axis_z;
    logic [15:0] fmt_x;
    logic [15:0] fmt_y;
    logic [15:0] fmt_z;
    logic [3:0]  eff_rate;
    logic        high_rate;
    logic        out_sample;
    logic        act_hit;
    logic        inact_hit;
    logic        all_quiet;
    logic        asleep;
    logic        act_en;
    logic        inact_en;
    logic        wr_hit;
    logic        cause_read;
    acp_pkg::acp_fmt_t  fmt;
    acp_pkg::acp_mode_t mode;
    acp_pkg::acp_evt_t  evt;

    function automatic logic [12:0] mag(input logic signed [RAW_W-1:0] v);
        logic [RAW_W-1:0] a;
        a   = v[RAW_W-1] ? RAW_W'(-v) : RAW_W'(v);
        mag = 13'(a);
    endfunction

    function automatic logic [12:0] thr_counts(input logic [7:0] t);
        thr_counts = 13'({5'h0, t} << acp_pkg::THR_SHIFT);
    endfunction

    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
        pick_byte = hi ? w[15:8] : w[7:0];
    endfunction

    // ==================================================================
    // configuration decode
    assign fmt.selftest  = format_reg[acp_pkg::FMT_SELFTEST_BIT];
    assign fmt.fixsens   = format_reg[acp_pkg::FMT_FIXSENS_BIT];
    assign fmt.justify   = format_reg[acp_pkg::FMT_JUSTIFY_BIT];
    assign fmt.range     = format_reg[1:0];
    assign mode.sleep    = sleep_link_reg[acp_pkg::SL_SLEEP_BIT];
    assign mode.autosleep = sleep_link_reg[acp_pkg::SL_AUTOSLEEP_BIT];
    assign mode.link     = sleep_link_reg[acp_pkg::SL_LINK_BIT];
    assign wr_hit        = wr_i;
    assign cause_read    = rd_i && addr_i == acp_pkg::REG_INT_CAUSE;

    // ==================================================================
    // control registers
    always_comb
    begin
        next_rate_power_reg = rate_power_reg;
        next_sleep_link_reg = sleep_link_reg;
        next_format_reg     = format_reg;
        next_int_en         = int_en;
        next_thr_act        = thr_act;
        next_thr_inact      = thr_inact;
        next_time_inact     = time_inact;
        if (wr_hit)
        begin
            unique case (addr_i)
                acp_pkg::REG_RATE:       next_rate_power_reg = {3'h0, wdata_i[4:0]};
                acp_pkg::REG_SLEEP_LINK: next_sleep_link_reg = wdata_i;
                acp_pkg::REG_FORMAT:     next_format_reg     = wdata_i;
                acp_pkg::REG_INT_EN:     next_int_en         = wdata_i;
                acp_pkg::REG_THR_ACT:    next_thr_act        = wdata_i;
                acp_pkg::REG_THR_INACT:  next_thr_inact      = wdata_i;
                acp_pkg::REG_TIME_INACT: next_time_inact     = wdata_i;
                default:                 next_int_en         = int_en;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rate_power_reg <= acp_pkg::RATE_RST;
            sleep_link_reg <= acp_pkg::SL_RST;
            format_reg     <= acp_pkg::FMT_RST;
            int_en         <= acp_pkg::INT_EN_RST;
            thr_act        <= acp_pkg::THR_RST;
            thr_inact      <= acp_pkg::THR_RST;
            time_inact     <= acp_pkg::THR_RST;
        end
        else if (ce_i)
        begin
            rate_power_reg <= next_rate_power_reg;
            sleep_link_reg <= next_sleep_link_reg;
            format_reg     <= next_format_reg;
            int_en         <= next_int_en;
            thr_act        <= next_thr_act;
            thr_inact      <= next_thr_inact;
            time_inact     <= next_time_inact;
        end
    end

    // ==================================================================
    // motion detection on undecimated samples
    always_comb
    begin
        act_hit   = sample_valid_i && act_en &&
                    (mag(sample_i.x) > thr_counts(thr_act) ||
                     mag(sample_i.y) > thr_counts(thr_act) ||
                     mag(sample_i.z) > thr_counts(thr_act));
        all_quiet = mag(sample_i.x) <= thr_counts(thr_inact) &&
                    mag(sample_i.y) <= thr_counts(thr_inact) &&
                    mag(sample_i.z) <= thr_counts(thr_inact);
        next_idle_cnt = idle_cnt;
        inact_hit     = 1'b0;
        if (!inact_en)
            next_idle_cnt = 8'h00;
        else if (sample_valid_i)
        begin
            if (!all_quiet)
                next_idle_cnt = 8'h00;
            else if (idle_cnt >= time_inact)
            begin
                // event on quiet sample time_inact+1, then restart the count, so an unlinked quiet stretch repeats it
                inact_hit     = 1'b1;
                next_idle_cnt = 8'h00;
            end
            else
                next_idle_cnt = idle_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            idle_cnt <= 8'h00;
        else if (ce_i)
            idle_cnt <= next_idle_cnt;
    end

    acp_sleep_ctl u_sleep
    (
        .clk_i         (clk_i),
        .nrst_i        (nrst_i),
        .ce_i          (ce_i),
        .mode_i        (mode),
        .act_hit_i     (act_hit),
        .inact_hit_i   (inact_hit),
        .act_pending_i (status[acp_pkg::INT_ACT_BIT]),
        .asleep_o      (asleep),
        .act_en_o      (act_en),
        .inact_en_o    (inact_en),
        .evt_o         (evt)
    );

    // ==================================================================
    // decimation and output words
    // asleep runs at the low rate
    assign eff_rate  = asleep ? acp_pkg::SLEEP_RATE : rate_power_reg[3:0];
    assign high_rate = eff_rate == acp_pkg::RATE_3200 || eff_rate == acp_pkg::RATE_1600;
    // low-power bit does not gate the sample path
    assign out_sample = sample_valid_i && dec_cnt >= (16'hffff >> ({1'b0, eff_rate} + 5'd1));

    acp_format #(.RAW_W(RAW_W)) u_fmt_x
    (
        .raw_i       (sample_i.x),
        .fmt_i       (fmt),
        .high_rate_i (high_rate),
        .word_o      (fmt_x)
    );
    acp_format #(.RAW_W(RAW_W)) u_fmt_y
    (
        .raw_i       (sample_i.y),
        .fmt_i       (fmt),
        .high_rate_i (high_rate),
        .word_o      (fmt_y)
    );
    acp_format #(.RAW_W(RAW_W)) u_fmt_z
    (
        .raw_i       (sample_i.z),
        .fmt_i       (fmt),
        .high_rate_i (high_rate),
        .word_o      (fmt_z)
    );

    always_comb
    begin
        next_dec_cnt = dec_cnt;
        next_axis_x  = axis_x;
        next_axis_y  = axis_y;
        next_axis_z  = axis_z;
        if (out_sample)
        begin
            next_dec_cnt = 16'h0000;
            next_axis_x  = fmt_x;
            next_axis_y  = fmt_y;
            next_axis_z  = fmt_z;
        end
        else if (sample_valid_i)
            next_dec_cnt = dec_cnt + 16'h0001;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dec_cnt <= 16'h0000;
            axis_x  <= 16'h0000;
            axis_y  <= 16'h0000;
            axis_z  <= 16'h0000;
        end
        else if (ce_i)
        begin
            dec_cnt <= next_dec_cnt;
            axis_x  <= next_axis_x;
            axis_y  <= next_axis_y;
            axis_z  <= next_axis_z;
        end
    end

    // ==================================================================
    // status, interrupt and read port
    always_comb
    begin
        next_status = status;
        if (cause_read)
        begin
            next_status[acp_pkg::INT_ACT_BIT]   = 1'b0;
            next_status[acp_pkg::INT_INACT_BIT] = 1'b0;
        end
        if (wr_hit && addr_i == acp_pkg::REG_INT_CLR)
            next_status = next_status & ~wdata_i;
        // set after clear so a coincident event is never lost
        if (out_sample)
            next_status[acp_pkg::INT_DRDY_BIT] = 1'b1;
        if (evt.act)
            next_status[acp_pkg::INT_ACT_BIT] = 1'b1;
        if (evt.inact)
            next_status[acp_pkg::INT_INACT_BIT] = 1'b1;
        next_irq       = |(next_status & int_en);
        next_selftest  = fmt.selftest;
        next_low_power = rate_power_reg[acp_pkg::RATE_LOWPWR_BIT];
        next_asleep    = asleep;
        next_rdata     = 8'h00;
        if (rd_i)
        begin
            unique case (addr_i)
                acp_pkg::REG_RATE:       next_rdata = rate_power_reg;
                acp_pkg::REG_SLEEP_LINK: next_rdata = sleep_link_reg;
                acp_pkg::REG_FORMAT:     next_rdata = format_reg;
                acp_pkg::REG_INT_EN:     next_rdata = int_en;
                acp_pkg::REG_INT_CAUSE:  next_rdata = status;
                acp_pkg::REG_THR_ACT:    next_rdata = thr_act;
                acp_pkg::REG_THR_INACT:  next_rdata = thr_inact;
                acp_pkg::REG_TIME_INACT: next_rdata = time_inact;
                acp_pkg::REG_AXIS_LOW_BYTE:    next_rdata = pick_byte(axis_x, 1'b0);
                acp_pkg::REG_AXIS_HIGH_BYTE:    next_rdata = pick_byte(axis_x, 1'b1);
                acp_pkg::REG_DATA_Y0:    next_rdata = pick_byte(axis_y, 1'b0);
                acp_pkg::REG_DATA_Y1:    next_rdata = pick_byte(axis_y, 1'b1);
                acp_pkg::REG_DATA_Z0:    next_rdata = pick_byte(axis_z, 1'b0);
                acp_pkg::REG_DATA_Z1:    next_rdata = pick_byte(axis_z, 1'b1);
                default:                 next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            status      <= 8'h00;
            irq_o       <= 1'b0;
            rdata_o     <= 8'h00;
            selftest_o  <= 1'b0;
            low_power_o <= 1'b0;
            asleep_o    <= 1'b0;
        end
        else if (ce_i)
        begin
            status      <= next_status;
            irq_o       <= next_irq;
            rdata_o     <= next_rdata;
            selftest_o  <= next_selftest;
            low_power_o <= next_low_power;
            asleep_o    <= next_asleep;
        end
    end
endmodule

/* tb/acp_top_assertions.sv */
`timescale 1ns/100ps
module acp_top_assertions
(
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       ce_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       irq_o,
    input wire logic       selftest_o,
    input wire logic       low_power_o,
    input wire logic       asleep_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // ==========================================
    // register port
    AST_RST_OUT: assert property (
        $rose(nrst_i) |-> !(irq_o || selftest_o || low_power_o || asleep_o || rdata_o != 8'h00))
        else $error("outputs not idle after reset");
    AST_RD_IDLE: assert property (
        ce_i && !rd_i |=> rdata_o == 8'h00)
        else $error("stale read data");
    AST_FMT_RB: assert property (
        (ce_i && wr_i && addr_i == 6'h31) ##1 (ce_i && rd_i && addr_i == 6'h31)
        |=> (rdata_o & 8'h8f) == ($past(wdata_i, 2) & 8'h8f))
        else $error("format readback wrong");
    AST_RATE_RB: assert property (
        (ce_i && wr_i && addr_i == 6'h2c) ##1 (ce_i && rd_i && addr_i == 6'h2c)
        |=> rdata_o == ($past(wdata_i, 2) & 8'h1f))
        else $error("rate readback wrong");
    // ==========================================
    // mode outputs
    AST_ST_ON: assert property (
        ce_i && wr_i && addr_i == 6'h31 && wdata_i[7] |-> ##[1:2] selftest_o)
        else $error("self test not on");
    AST_ST_OFF: assert property (
        ce_i && wr_i && addr_i == 6'h31 && !wdata_i[7] |-> ##[1:2] !selftest_o)
        else $error("self test not off");
    AST_SLEEP: assert property (
        ce_i && wr_i && addr_i == 6'h2d && wdata_i[2] |-> ##[1:2] asleep_o)
        else $error("sleep bit ignored");
    AST_IRQ_MASK: assert property (
        (ce_i && wr_i && addr_i == 6'h2e && wdata_i == 8'h00) ##1 !wr_i |=> !irq_o)
        else $error("irq while all masked");
endmodule

/* tb/acp_host_model.sv */
`timescale 1ns/100ps
module acp_host_model
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic [5:0]      addr_o = 6'h00,
    output logic [7:0]      wdata_o = 8'h00,
    output logic            wr_o = 1'b0,
    output logic            rd_o = 1'b0
);
    // ==========================================
    // bus cycles, each begun just after an edge
    // write leaves its strobe up so a read may follow with no gap
    task automatic wr_t(input logic [5:0] a, input logic [7:0] d);
        wr_o <= 1'b1;
        rd_o <= 1'b0;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
    endtask
    task automatic rd_t(input logic [5:0] a, output logic [7:0] d);
        wr_o <= 1'b0;
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(negedge clk_i);
        d = rdata_i;
        @(posedge clk_i);
    endtask
    // released lines flip so a stale value never looks valid
    task automatic idle_t(input int n);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~addr_o;
        wdata_o <= ~wdata_o;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic st_cfg(input logic on);
        wr_t(6'h2c, 8'h0f);
        wr_t(6'h31, {on, 7'h0b});
        idle_t(2);
    endtask
endmodule

/* tb/tb_accel_power_selftest_format.sv */
`timescale 1ns/100ps
module tb_accel_power_selftest_format;
    logic               clk_i = 1'b0;
    logic               nrst_i = 1'b0;
    logic               ce_i = 1'b1;
    logic               sv = 1'b0;
    acp_pkg::acp_axes_t smp = '0;
    logic [5:0]         addr_i;
    logic [7:0]         wdata_i, rdata_o, d;
    logic               wr_i, rd_i, irq_o, st_o, lp_o, slp_o;
    logic [31:0]        seed = 32'hfd93;
    logic [31:0]        r;
    logic [15:0]        e;
    logic [15:0]        exp_q[$];
    int                 raw[3];
    int                 lp;
    int                 fails = 0;
    int                 samples_checked = 0;
    int                 cyc = 0;
    acp_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_valid_i(sv),
        .sample_i(smp), .irq_o(irq_o), .selftest_o(st_o), .low_power_o(lp_o), .asleep_o(slp_o));
    acp_host_model host_u (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    always #5 clk_i = ~clk_i;
    // whole run needs about 1000 cycles
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fails++;
            results();
        end
    end
    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] fmt_m(int raw, int fs, int js, int rg, int hi);
        int w;
        int v;
        w = fs ? 10 + rg : 10;
        v = fs ? raw : raw >>> rg;
        v = v > (1 << (w - 1)) - 1 ? (1 << (w - 1)) - 1 : v;
        v = v < -(1 << (w - 1)) ? -(1 << (w - 1)) : v;
        v = hi && (fs || rg == 0) ? v & ~1 : v;
        v = js ? v << (16 - w) : v;
        return v[15:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        samples_checked++;
        if (got !== want)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] m, input logic [7:0] want);
        logic [7:0] v;
        host_u.rd_t(a, v);
        chk({8'h00, v & m}, {8'h00, want});
    endtask
    // strobe stays up across the n samples
    task automatic smp_t(input int x, input int y, input int z, input int n);
        sv <= 1'b1;
        smp <= {x[12:0], y[12:0], z[12:0]};
        host_u.idle_t(n);
        sv <= 1'b0;
        smp <= ~smp;
        host_u.idle_t(3);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================
    // tests
    initial
    begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rdc(6'h2c, 8'hff, 8'h0a);
        rdc(6'h31, 8'hff, 8'h00);
        rdc(6'h3f, 8'hff, 8'h00);
        host_u.wr_t(6'h2c, 8'hff);
        rdc(6'h2c, 8'hff, 8'h1f);
        // enable low freezes state, so this write must be lost
        ce_i <= 1'b0;
        host_u.wr_t(6'h2c, 8'h05);
        ce_i <= 1'b1;
        host_u.idle_t(1);
        rdc(6'h2c, 8'hff, 8'h1f);
        host_u.wr_t(6'h31, 8'hff);
        rdc(6'h31, 8'h8f, 8'h8f);
        rdc(6'h3a, 8'hff, 8'h00);
        $display("registers end");
        // decimation grows so the count never overshoots
        for (int c = 15; c > 12; c--)
        begin
            for (int m = 0; m < 16; m++)
            begin
                lp = int'(rnd() & 32'h1);
                host_u.wr_t(6'h2c, {3'h0, lp[0], c[3:0]});
                host_u.wr_t(6'h31, {4'h0, m[3:0]});
                for (int k = 0; k < 3; k++)
                begin
                    r = rnd();
                    raw[k] = int'($signed(r[12:0]));
                    exp_q.push_back(fmt_m(raw[k], m[3], m[2], m[1:0], c > 13));
                end
                smp_t(raw[0], raw[1], raw[2], 1 << (15 - c));
                for (int a = 0; a < 6; a++)
                begin
                    host_u.rd_t(6'h32 + 6'(a), d);
                    e = exp_q[a / 2];
                    chk({8'h00, d}, {8'h00, a[0] ? e[15:8] : e[7:0]});
                end
                exp_q.delete();
                chk(16'(lp_o), 16'(lp));
            end
        end
        $display("formatting end");
        host_u.wr_t(6'h2c, 8'h1f);
        host_u.wr_t(6'h3a, 8'hff);
        host_u.wr_t(6'h2e, 8'h80);
        host_u.idle_t(2);
        chk(16'(irq_o), 16'h0);
        smp_t(5, 5, 5, 1);
        chk(16'(irq_o), 16'h1);
        host_u.wr_t(6'h2e, 8'h00);
        rdc(6'h30, 8'h80, 8'h80);
        chk(16'(irq_o), 16'h0);
        host_u.wr_t(6'h2e, 8'h80);
        host_u.wr_t(6'h3a, 8'h80);
        host_u.idle_t(2);
        chk(16'(irq_o), 16'h0);
        $display("interrupts end");
        host_u.st_cfg(1'b1);
        chk(16'(st_o), 16'h1);
        smp_t(0, 0, 0, 4);
        rdc(6'h31, 8'h8f, 8'h8b);
        host_u.st_cfg(1'b0);
        chk(16'(st_o), 16'h0);
        $display("self test end");
        host_u.wr_t(6'h24, 8'h20);
        host_u.wr_t(6'h25, 8'h10);
        host_u.wr_t(6'h26, 8'h00);
        host_u.wr_t(6'h2e, 8'h18);
        host_u.wr_t(6'h2d, 8'h30);
        host_u.rd_t(6'h30, d);
        smp_t(0, 0, 0, 1);
        chk(16'(slp_o), 16'h1);
        rdc(6'h30, 8'h18, 8'h08);
        smp_t(0, 0, 0, 1);
        rdc(6'h30, 8'h18, 8'h00);
        smp_t(1000, 0, 0, 1);
        chk(16'(slp_o), 16'h0);
        smp_t(0, 0, 0, 1);
        chk(16'(slp_o), 16'h0);
        rdc(6'h30, 8'h18, 8'h18);
        host_u.wr_t(6'h2d, 8'h04);
        host_u.idle_t(2);
        chk(16'(slp_o), 16'h1);
        $display("link end");
        results();
    end
endmodule
bind acp_top acp_top_assertions chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .selftest_o(selftest_o), .low_power_o(low_power_o), .asleep_o(asleep_o));
